// ==== aidr_top.sv ====
// Diagnostic record, timestamp and interrupt logic of a two-channel analog input
// Functional notes
// - Underflow flags: bit per channel, rest zero
// - 32-bit microsecond counter starts at zero
// - Counter wraps to zero after maximum
// - Hardware event stamp is counter low half
// - Record stamp is counter at diag event
// - Enabled diag interrupt raised with record
// - Going interrupt issued when cause clears
// - Events between incoming and going discarded
// - Fault indicator lit incoming until going
// - Record set 01h full, 00h first four
// - Index 2F01h full, 2F00h first four
// - Fieldbus index 5005h, subindex per group
// - Error summary byte bit meanings
// - Internal fault byte bits 3, 4, 6
// - Diag bits per channel reads 08h
// - Channel count reads 02h
// - Group fault bit per channel group
// - Channel detail bits 0, 5, 6, 7
// - Overflow flags: bit per channel, rest zero
// - Monitored limit crossing raises hardware interrupt unless the previous one is unacknowledged
`timescale 1ns/1ns
module aidr_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic param_wr,
	input wire logic [7:0] param_data,
	input wire logic [1:0] limit_en,
	input wire logic [1:0] cfg_err_pin,
	input wire logic [1:0] range_under_pin,
	input wire logic [1:0] range_over_pin,
	input wire logic [1:0] above_limit_pin,
	input wire logic [1:0] below_limit_pin,
	input wire logic buf_overflow_pin,
	input wire logic comm_error_pin,
	input wire logic aux_missing_pin,
	input wire logic hw_irq_ack,
	input wire logic rd_valid,
	input wire aidr_pkg::aidr_rd_req_t rd_req,
	output logic rd_ready,
	output logic rd_done,
	output logic [31:0] rd_data,
	output logic rd_error,
	output logic hw_irq,
	output logic [7:0] limit_overflow_flags,
	output logic [7:0] limit_underflow_flags,
	output logic [15:0] event_timestamp_low,
	output logic diag_in,
	output logic diag_go,
	output logic module_fault_indicator,
	output logic diag_interrupt_enable
);
	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	logic [12:0] pins;
	logic [1:0] cfg_err, range_under, range_over, above_lim, below_lim;
	logic buf_ovf, comm_err, aux_miss;

	aidr_sync #(.WIDTH(13)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.pin({cfg_err_pin, range_under_pin, range_over_pin, above_limit_pin,
			below_limit_pin, buf_overflow_pin, comm_error_pin, aux_missing_pin}),
		.level(pins)
	);
	assign {cfg_err, range_under, range_over, above_lim, below_lim, buf_ovf, comm_err,
		aux_miss} = pins;

	// ----------------------------------------------------------------
	// Microsecond timestamp
	// ----------------------------------------------------------------
	logic [4:0] pre, next_pre;
	logic us_tick;
	logic [31:0] ts, next_ts;

	// Prescaler makes one tick per microsecond; counter wraps naturally
	always_comb begin
		us_tick = (pre == 5'(aidr_pkg::US_CYCLES - 1));
		next_pre = us_tick ? 5'h00 : pre + 5'h01;
		next_ts = us_tick ? ts + 32'h0000_0001 : ts;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pre <= 5'h00;
			ts <= aidr_pkg::TS_RESET;
		end else begin
			pre <= next_pre;
			ts <= next_ts;
		end
	end

	// ----------------------------------------------------------------
	// Diagnostic interrupt enable parameter
	// ----------------------------------------------------------------
	logic next_en;

	// Only the two documented codes change the setting
	always_comb begin
		next_en = diag_interrupt_enable;
		if (param_wr && param_data == aidr_pkg::DIAG_ON_CODE)
			next_en = 1'b1;
		else if (param_wr && param_data == aidr_pkg::DIAG_OFF_CODE)
			next_en = 1'b0;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			diag_interrupt_enable <= 1'b0;
		else
			diag_interrupt_enable <= next_en;
	end

	// ----------------------------------------------------------------
	// Limit monitoring and hardware interrupt
	// ----------------------------------------------------------------
	logic [3:0] hit, hit_q, rise;
	logic [1:0] lost, next_lost, lost_set;
	logic hw_pend, next_pend, next_hw;
	logic [7:0] next_ovf, next_unf;
	logic [15:0] next_evt;
	logic diag_capture;

	// New crossing while the previous one is unacknowledged is lost
	always_comb begin
		hit = {above_lim & limit_en, below_lim & limit_en};
		rise = hit & ~hit_q;
		next_pend = hw_pend & ~hw_irq_ack;
		next_hw = 1'b0;
		next_ovf = limit_overflow_flags;
		next_unf = limit_underflow_flags;
		next_evt = event_timestamp_low;
		lost_set = 2'b00;
		if (|rise) begin
			if (next_pend) begin
				lost_set = rise[3:2] | rise[1:0];
			end else begin
				next_hw = 1'b1;
				next_pend = 1'b1;
				next_ovf = {6'h00, rise[3:2]};
				next_unf = {6'h00, rise[1:0]};
				next_evt = ts[15:0];
			end
		end
		// A loss arriving with the capture survives it
		next_lost = (lost & ~{2{diag_capture}}) | lost_set;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hit_q <= 4'h0;
			hw_pend <= 1'b0;
			hw_irq <= 1'b0;
			lost <= 2'b00;
			limit_overflow_flags <= aidr_pkg::RST_ZERO_BYTE;
			limit_underflow_flags <= aidr_pkg::RST_ZERO_BYTE;
			event_timestamp_low <= 16'h0000;
		end else begin
			hit_q <= hit;
			hw_pend <= next_pend;
			hw_irq <= next_hw;
			lost <= next_lost;
			limit_overflow_flags <= next_ovf;
			limit_underflow_flags <= next_unf;
			event_timestamp_low <= next_evt;
		end
	end

	// ----------------------------------------------------------------
	// Live error bytes
	// ----------------------------------------------------------------
	logic [7:0] ch_live [2];
	logic [7:0] sum_live, fault_live, group_live;
	logic cause;

	always_comb begin
		for (int c = 0; c < 2; c++)
			ch_live[c] = {range_over[c], range_under[c], lost[c], 4'h0, cfg_err[c]};
		group_live = {6'h00, |ch_live[1], |ch_live[0]};
		fault_live = 8'h00;
		fault_live[aidr_pkg::ED_BUF_OVF] = buf_ovf;
		fault_live[aidr_pkg::ED_COMM] = comm_err;
		fault_live[aidr_pkg::ED_HW_LOST] = |lost;
		sum_live = 8'h00;
		sum_live[aidr_pkg::EA_MODULE_FAIL] = buf_ovf | comm_err;
		sum_live[aidr_pkg::EA_INTERNAL] = buf_ovf | comm_err | (|lost);
		sum_live[aidr_pkg::EA_EXTERNAL] = (|range_over) | (|range_under) | aux_miss;
		sum_live[aidr_pkg::EA_CHANNEL] = |group_live;
		sum_live[aidr_pkg::EA_AUX_MISSING] = aux_miss;
		sum_live[aidr_pkg::EA_PARAM] = |cfg_err;
		cause = |sum_live;
	end

	// ----------------------------------------------------------------
	// Diagnostic interrupt sequence
	// ----------------------------------------------------------------
	aidr_pkg::aidr_diag_t state, next_state;
	aidr_pkg::aidr_record_t rec, next_rec;
	logic next_in, next_go;

	// Record is frozen while active, so later events are dropped
	always_comb begin
		next_state = state;
		next_rec = rec;
		next_in = 1'b0;
		next_go = 1'b0;
		diag_capture = 1'b0;
		unique case (state)
			aidr_pkg::DIAG_QUIET: begin
				if (diag_interrupt_enable && cause) begin
					diag_capture = 1'b1;
					next_in = 1'b1;
					next_state = aidr_pkg::DIAG_ACTIVE;
					next_rec = {sum_live, fault_live, group_live, ch_live[1],
						ch_live[0], ts};
				end
			end
			aidr_pkg::DIAG_ACTIVE: begin
				if (!cause) begin
					next_go = 1'b1;
					next_state = aidr_pkg::DIAG_QUIET;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= aidr_pkg::DIAG_QUIET;
			rec <= '0;
			diag_in <= 1'b0;
			diag_go <= 1'b0;
		end else begin
			state <= next_state;
			rec <= next_rec;
			diag_in <= next_in;
			diag_go <= next_go;
		end
	end

	assign module_fault_indicator = (state == aidr_pkg::DIAG_ACTIVE);

	// ----------------------------------------------------------------
	// Record read port
	// ----------------------------------------------------------------
	// Byte of the record at a subindex address; reserved bytes read zero
	function automatic logic [7:0] rec_byte(aidr_pkg::aidr_record_t r, logic [7:0] a);
		logic [7:0] b;
		b = 8'h00;
		case (a)
			aidr_pkg::OFS_MODULE_ERROR_SUMMARY: b = r.summary;
			aidr_pkg::OFS_MODULE_CLASS_INFO: b = aidr_pkg::RST_MODULE_CLASS_INFO;
			aidr_pkg::OFS_INTERNAL_FAULT_FLAGS: b = r.internal;
			aidr_pkg::OFS_CHANNEL_KIND_CODE: b = aidr_pkg::RST_CHANNEL_KIND_CODE;
			aidr_pkg::OFS_DIAG_BITS_PER_CHANNEL: b = aidr_pkg::RST_DIAG_BITS_PER_CHANNEL;
			aidr_pkg::OFS_CHANNEL_COUNT: b = aidr_pkg::RST_CHANNEL_COUNT;
			aidr_pkg::OFS_CHANNEL_GROUP_FAULT: b = r.group;
			aidr_pkg::OFS_CHAN0_FAULT_DETAIL: b = r.ch0;
			aidr_pkg::OFS_CHAN1_FAULT_DETAIL: b = r.ch1;
			aidr_pkg::OFS_DIAG_TIMESTAMP: b = r.ts[7:0];
			aidr_pkg::OFS_DIAG_TIMESTAMP + 8'h01: b = r.ts[15:8];
			aidr_pkg::OFS_DIAG_TIMESTAMP + 8'h02: b = r.ts[23:16];
			aidr_pkg::OFS_DIAG_TIMESTAMP + 8'h03: b = r.ts[31:24];
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	logic next_done, next_rerr, full, head;
	logic [31:0] next_rdata;
	logic [7:0] addr;

	assign rd_ready = 1'b1;

	// Decode path and index, answer one cycle after the request
	always_comb begin
		next_done = rd_valid;
		next_rdata = 32'h0000_0000;
		next_rerr = 1'b0;
		full = 1'b0;
		head = 1'b0;
		addr = rd_req.sub + aidr_pkg::OFS_MODULE_ERROR_SUMMARY;
		unique case (rd_req.path)
			aidr_pkg::PATH_RECORD_SET: begin
				full = (rd_req.index == aidr_pkg::RS_FULL);
				head = (rd_req.index == aidr_pkg::RS_HEAD);
			end
			aidr_pkg::PATH_CANOPEN: begin
				full = (rd_req.index == aidr_pkg::CO_FULL);
				head = (rd_req.index == aidr_pkg::CO_HEAD);
			end
			default: begin
			end
		endcase
		if (rd_req.path == aidr_pkg::PATH_FIELDBUS) begin
			if (rd_req.index == aidr_pkg::FB_INDEX && rd_req.sub == aidr_pkg::OFS_DIAG_TIMESTAMP)
				next_rdata = rec.ts;
			else if (rd_req.index == aidr_pkg::FB_INDEX &&
				rd_req.sub >= aidr_pkg::OFS_MODULE_ERROR_SUMMARY &&
				rd_req.sub <= aidr_pkg::OFS_UNUSED_LAST)
				next_rdata = {24'h000000, rec_byte(rec, rd_req.sub)};
			else
				next_rerr = 1'b1;
		end else if ((full && rd_req.sub < aidr_pkg::RECORD_BYTES) ||
			(head && rd_req.sub < aidr_pkg::HEAD_BYTES)) begin
			next_rdata = {24'h000000, rec_byte(rec, addr)};
		end else begin
			next_rerr = 1'b1;
		end
		if (!rd_valid) begin
			next_rdata = rd_data;
			next_rerr = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_done <= 1'b0;
			rd_data <= 32'h0000_0000;
			rd_error <= 1'b0;
		end else begin
			rd_done <= next_done;
			rd_data <= next_rdata;
			rd_error <= next_rerr;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_tick_step: assert property (us_tick |=> ts == $past(ts) + 32'h1)
		else $error("timestamp did not step on tick");
	a_tick_spacing: assert property (us_tick |-> ##20 us_tick)
		else $error("tick spacing is not one microsecond");
	a_ts_wrap: assert property (us_tick && ts == 32'hffff_ffff |=> ts == 32'h0)
		else $error("timestamp did not wrap to zero");
	a_hw_stamp: assert property (hw_irq |-> event_timestamp_low == $past(ts[15:0]))
		else $error("event stamp is not counter low half");
	a_flag_rsvd: assert property (limit_underflow_flags[7:2] == 6'h0 &&
		limit_overflow_flags[7:2] == 6'h0)
		else $error("reserved limit flag bits set");
	a_diag_stamp: assert property (diag_in |-> rec.ts == $past(ts))
		else $error("record stamp wrong");
	a_diag_gate: assert property (diag_in |-> $past(diag_interrupt_enable))
		else $error("incoming interrupt while disabled");
	a_going_auto: assert property (module_fault_indicator && !cause |=> diag_go &&
		!module_fault_indicator)
		else $error("going interrupt missing");
	a_record_frozen: assert property (module_fault_indicator && !diag_in |-> $stable(rec))
		else $error("record changed while active");
	a_led_on: assert property (diag_in |-> module_fault_indicator)
		else $error("fault indicator not lit");
	a_head_limit: assert property (rd_valid && rd_req.path == aidr_pkg::PATH_RECORD_SET &&
		rd_req.index == aidr_pkg::RS_HEAD && rd_req.sub >= 8'h04 |=> rd_error)
		else $error("head record read beyond four bytes");

	c_incoming: cover property (diag_in);
	c_going: cover property (diag_in ##[1:1000] diag_go);
	c_hw_irq: cover property (hw_irq);
	c_lost: cover property (|lost_set);
endmodule

// ==== aidr_pkg.sv ====
// Shared constants and types of the analog input diagnostic record
package aidr_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int TICK_PER_S = 1_000_000;
	localparam int US_CYCLES = CLK_HZ / TICK_PER_S;
	localparam logic [31:0] TS_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Record byte offsets (subindex numbering)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_MODULE_ERROR_SUMMARY = 8'h02;
	localparam logic [7:0] OFS_MODULE_CLASS_INFO = 8'h03;
	localparam logic [7:0] OFS_RESERVED_ERROR_BYTE = 8'h04;
	localparam logic [7:0] OFS_INTERNAL_FAULT_FLAGS = 8'h05;
	localparam logic [7:0] OFS_CHANNEL_KIND_CODE = 8'h06;
	localparam logic [7:0] OFS_DIAG_BITS_PER_CHANNEL = 8'h07;
	localparam logic [7:0] OFS_CHANNEL_COUNT = 8'h08;
	localparam logic [7:0] OFS_CHANNEL_GROUP_FAULT = 8'h09;
	localparam logic [7:0] OFS_CHAN0_FAULT_DETAIL = 8'h0a;
	localparam logic [7:0] OFS_CHAN1_FAULT_DETAIL = 8'h0b;
	localparam logic [7:0] OFS_UNUSED_CHAN_FAULT_BYTES = 8'h0c;
	localparam logic [7:0] OFS_UNUSED_LAST = 8'h11;
	localparam logic [7:0] OFS_DIAG_TIMESTAMP = 8'h13;
	localparam logic [7:0] RECORD_BYTES = OFS_DIAG_TIMESTAMP + 8'h04 - OFS_MODULE_ERROR_SUMMARY;
	localparam logic [7:0] HEAD_BYTES = 8'h04;

	// ----------------------------------------------------------------
	// Values after reset and fixed contents
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO_BYTE = 8'h00;
	localparam logic [7:0] RST_MODULE_CLASS_INFO = 8'h15;
	localparam logic [7:0] RST_CHANNEL_KIND_CODE = 8'h71;
	localparam logic [7:0] RST_DIAG_BITS_PER_CHANNEL = 8'h08;
	localparam logic [7:0] RST_CHANNEL_COUNT = 8'h02;

	// ----------------------------------------------------------------
	// Access codes
	// ----------------------------------------------------------------
	localparam logic [15:0] RS_FULL = 16'h0001;
	localparam logic [15:0] RS_HEAD = 16'h0000;
	localparam logic [15:0] CO_FULL = 16'h2f01;
	localparam logic [15:0] CO_HEAD = 16'h2f00;
	localparam logic [15:0] FB_INDEX = 16'h5005;
	localparam logic [7:0] DIAG_ON_CODE = 8'h40;
	localparam logic [7:0] DIAG_OFF_CODE = 8'h00;

	// ----------------------------------------------------------------
	// Bit positions
	// ----------------------------------------------------------------
	localparam int EA_MODULE_FAIL = 0;
	localparam int EA_INTERNAL = 1;
	localparam int EA_EXTERNAL = 2;
	localparam int EA_CHANNEL = 3;
	localparam int EA_AUX_MISSING = 4;
	localparam int EA_PARAM = 7;
	localparam int ED_BUF_OVF = 3;
	localparam int ED_COMM = 4;
	localparam int ED_HW_LOST = 6;

	typedef enum logic [1:0] {PATH_RECORD_SET, PATH_CANOPEN, PATH_FIELDBUS} aidr_path_t;
	typedef enum logic {DIAG_QUIET, DIAG_ACTIVE} aidr_diag_t;

	// Read request: path, record or object index, byte or subindex
	typedef struct packed {
		aidr_path_t path;
		logic [15:0] index;
		logic [7:0] sub;
	} aidr_rd_req_t;

	// Captured diagnostic record contents
	typedef struct packed {
		logic [7:0] summary;
		logic [7:0] internal;
		logic [7:0] group;
		logic [7:0] ch1;
		logic [7:0] ch0;
		logic [31:0] ts;
	} aidr_record_t;

endpackage

// ==== aidr_sync.sv ====
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module aidr_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			level <= '0;
		end else begin
			meta <= pin;
			level <= meta;
		end
	end
endmodule

// ==== aidr_host_model.sv ====
// Backplane master model: record reads and diagnostic enable parameter writes
`timescale 1ns/1ns
module aidr_host_model (
	input wire logic clock,
	input wire logic rd_done,
	input wire logic [31:0] rd_data,
	input wire logic rd_error,
	output logic rd_valid,
	output aidr_pkg::aidr_rd_req_t rd_req,
	output logic param_wr,
	output logic [7:0] param_data
);
	// Idle levels at time zero
	initial begin
		rd_valid = 1'b0;
		rd_req = '0;
		param_wr = 1'b0;
		param_data = 8'h00;
	end

	// One read request, answer taken when the done pulse is seen
	task automatic rd(input aidr_pkg::aidr_path_t p, input logic [15:0] idx, input logic [7:0] sub,
		output logic [31:0] d, output logic e);
		@(negedge clock);
		rd_req = '{p, idx, sub};
		rd_valid = 1'b1;
		@(negedge clock);
		rd_valid = 1'b0;
		rd_req = ~rd_req; // Released request shows no stale value
		for (int i = 0; i < 8 && rd_done !== 1'b1; i++) begin
			@(negedge clock);
		end
		d = rd_data;
		e = rd_error;
	endtask

	// Parameter byte write, 40h enables and 00h disables
	task automatic param(input logic [7:0] v);
		@(negedge clock);
		param_wr = 1'b1;
		param_data = v;
		@(negedge clock);
		param_wr = 1'b0;
		param_data = ~v;
	endtask
endmodule

// ==== aidr_tb_top.sv ====
// Self-checking testbench of the analog input diagnostic record
`timescale 1ns/1ns
module aidr_tb_top;
	logic clock, rst_n, param_wr, rd_valid, rd_ready, rd_done, rd_error, hw_irq, hw_irq_ack;
	logic buf_overflow_pin, comm_error_pin, aux_missing_pin;
	logic diag_in, diag_go, module_fault_indicator, diag_interrupt_enable;
	logic [1:0] limit_en, cfg_err_pin, range_under_pin, range_over_pin;
	logic [1:0] above_limit_pin, below_limit_pin;
	logic [7:0] param_data, limit_overflow_flags, limit_underflow_flags;
	logic [15:0] event_timestamp_low;
	logic [31:0] rd_data;
	aidr_pkg::aidr_rd_req_t rd_req;
	int n_checks = 0;
	int bad_count = 0;
	int cyc = 0;
	int ev_cyc = 0;
	int ev[3] = '{0, 0, 0};

	aidr_top u_dut (.clock(clock), .rst_n(rst_n), .param_wr(param_wr), .param_data(param_data),
		.limit_en(limit_en), .cfg_err_pin(cfg_err_pin), .range_under_pin(range_under_pin),
		.range_over_pin(range_over_pin), .above_limit_pin(above_limit_pin),
		.below_limit_pin(below_limit_pin), .buf_overflow_pin(buf_overflow_pin),
		.comm_error_pin(comm_error_pin), .aux_missing_pin(aux_missing_pin),
		.hw_irq_ack(hw_irq_ack), .rd_valid(rd_valid), .rd_req(rd_req), .rd_ready(rd_ready),
		.rd_done(rd_done), .rd_data(rd_data), .rd_error(rd_error), .hw_irq(hw_irq),
		.limit_overflow_flags(limit_overflow_flags), .limit_underflow_flags(limit_underflow_flags),
		.event_timestamp_low(event_timestamp_low), .diag_in(diag_in), .diag_go(diag_go),
		.module_fault_indicator(module_fault_indicator),
		.diag_interrupt_enable(diag_interrupt_enable));

	aidr_host_model u_host (.clock(clock), .rd_done(rd_done), .rd_data(rd_data),
		.rd_error(rd_error), .rd_valid(rd_valid), .rd_req(rd_req), .param_wr(param_wr),
		.param_data(param_data));

	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Cycle count and event pulse counters
	always @(posedge clock) begin
		cyc++;
		if (hw_irq === 1'b1) ev[0]++;
		if (diag_in === 1'b1) begin
			ev[1]++;
			ev_cyc = cyc;
		end
		if (diag_go === 1'b1) ev[2]++;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_rd(input logic [1:0] p, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] exp, input logic err);
		logic [31:0] d;
		logic e;
		u_host.rd(aidr_pkg::aidr_path_t'(p), idx, sub, d, e);
		check($sformatf("read %h/%h", idx, sub), exp, d);
		check("read error", {31'h0, err}, {31'h0, e});
	endtask

	// Waits for an event count, or watches a quiet span when hold is set
	task automatic wait_ev(input int k, input int want, input bit hold);
		for (int i = 0; i < 12 && (hold || ev[k] != want); i++) begin
			@(negedge clock);
		end
		check($sformatf("event %0d count", k), want, ev[k]);
	endtask

	task automatic ack;
		hw_irq_ack = 1'b1;
		@(negedge clock);
		hw_irq_ack = 1'b0;
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reg;
		chk_rd(2'h0, 16'h0001, 8'h00, 32'h00, 1'b0);
		chk_rd(2'h0, 16'h0001, 8'h01, 32'h15, 1'b0);
		chk_rd(2'h0, 16'h0001, 8'h02, 32'h00, 1'b0);
		chk_rd(2'h1, 16'h2f01, 8'h04, 32'h71, 1'b0);
		chk_rd(2'h1, 16'h2f00, 8'h03, 32'h00, 1'b0);
		chk_rd(2'h1, 16'h2f00, 8'h04, 32'h00, 1'b1);
		chk_rd(2'h0, 16'h0000, 8'h01, 32'h15, 1'b0);
		chk_rd(2'h0, 16'h0000, 8'h04, 32'h00, 1'b1);
		chk_rd(2'h2, 16'h5005, 8'h07, 32'h08, 1'b0);
		chk_rd(2'h2, 16'h5005, 8'h08, 32'h02, 1'b0);
		chk_rd(2'h2, 16'h5005, 8'h12, 32'h00, 1'b1);
		chk_rd(2'h2, 16'h5000, 8'h02, 32'h00, 1'b1);
		for (int k = 10; k < 17; k++) chk_rd(2'h0, 16'h0001, 8'(k), 32'h00, 1'b0);
		check("ready", 32'h1, {31'h0, rd_ready});
		$display("t_reg done");
	endtask

	task automatic t_hw;
		logic [15:0] ts0;
		int t0;
		limit_en = 2'h1;
		t0 = cyc;
		below_limit_pin[0] = 1'b1;
		wait_ev(0, 1, 1'b0);
		check("underflow", 8'h01, limit_underflow_flags);
		check("overflow", 8'h00, limit_overflow_flags);
		ts0 = event_timestamp_low;
		ack;
		while (cyc < t0 + 200) @(negedge clock);
		limit_en = 2'h3;
		above_limit_pin[1] = 1'b1;
		wait_ev(0, 2, 1'b0);
		check("overflow", 8'h02, limit_overflow_flags);
		check("underflow", 8'h00, limit_underflow_flags);
		check("stamp step", 16'h000a, event_timestamp_low - ts0);
		ack;
		limit_en = 2'h0;
		above_limit_pin[0] = 1'b1;
		wait_ev(0, 2, 1'b1);
		above_limit_pin = 2'h0;
		below_limit_pin = 2'h0;
		$display("t_hw done");
	endtask

	task automatic t_diag;
		logic [31:0] d, s;
		logic e;
		range_over_pin[0] = 1'b1;
		wait_ev(1, 0, 1'b1);
		u_host.param(8'h40);
		check("enable", 32'h1, {31'h0, diag_interrupt_enable});
		wait_ev(1, 1, 1'b0);
		check("indicator", 32'h1, {31'h0, module_fault_indicator});
		chk_rd(2'h0, 16'h0001, 8'h00, 32'h0c, 1'b0);
		chk_rd(2'h0, 16'h0001, 8'h07, 32'h01, 1'b0);
		chk_rd(2'h0, 16'h0001, 8'h08, 32'h80, 1'b0);
		cfg_err_pin[1] = 1'b1;
		wait_ev(1, 1, 1'b1);
		chk_rd(2'h0, 16'h0001, 8'h09, 32'h00, 1'b0);
		s = 32'h0;
		for (int k = 17; k < 21; k++) begin
			u_host.rd(aidr_pkg::PATH_RECORD_SET, 16'h0001, 8'(k), d, e);
			s[(k - 17) * 8 +: 8] = d[7:0];
		end
		chk_rd(2'h2, 16'h5005, 8'h13, s, 1'b0);
		// Three reset edges, and the pulse is counted one edge after the capture
		check("record stamp", 32'((ev_cyc - 5) / aidr_pkg::US_CYCLES), s);
		range_over_pin = 2'h0;
		cfg_err_pin = 2'h0;
		wait_ev(2, 1, 1'b0);
		check("indicator", 32'h0, {31'h0, module_fault_indicator});
		$display("t_diag done");
	endtask

	task automatic t_lost;
		limit_en = 2'h3;
		below_limit_pin[0] = 1'b1;
		wait_ev(0, 3, 1'b0);
		below_limit_pin[1] = 1'b1;
		wait_ev(0, 3, 1'b1);
		check("diag count", 32'h2, ev[1]);
		chk_rd(2'h0, 16'h0001, 8'h03, 32'h40, 1'b0);
		chk_rd(2'h0, 16'h0001, 8'h09, 32'h20, 1'b0);
		wait_ev(2, 2, 1'b0);
		ack;
		below_limit_pin = 2'h0;
		limit_en = 2'h0;
		buf_overflow_pin = 1'b1;
		comm_error_pin = 1'b1;
		aux_missing_pin = 1'b1;
		range_under_pin[1] = 1'b1;
		cfg_err_pin[0] = 1'b1;
		wait_ev(1, 3, 1'b0);
		chk_rd(2'h0, 16'h0001, 8'h00, 32'h9f, 1'b0);
		chk_rd(2'h0, 16'h0001, 8'h03, 32'h18, 1'b0);
		chk_rd(2'h0, 16'h0001, 8'h07, 32'h03, 1'b0);
		chk_rd(2'h0, 16'h0001, 8'h08, 32'h01, 1'b0);
		chk_rd(2'h0, 16'h0001, 8'h09, 32'h40, 1'b0);
		buf_overflow_pin = 1'b0;
		comm_error_pin = 1'b0;
		aux_missing_pin = 1'b0;
		range_under_pin = 2'h0;
		cfg_err_pin = 2'h0;
		wait_ev(2, 3, 1'b0);
		$display("t_lost done");
	endtask

	// Reset, then the scenarios in order
	initial begin
		rst_n = 1'b0;
		hw_irq_ack = 1'b0;
		limit_en = 2'h0;
		cfg_err_pin = 2'h0;
		range_under_pin = 2'h0;
		range_over_pin = 2'h0;
		above_limit_pin = 2'h0;
		below_limit_pin = 2'h0;
		buf_overflow_pin = 1'b0;
		comm_error_pin = 1'b0;
		aux_missing_pin = 1'b0;
		repeat (3) @(negedge clock);
		rst_n = 1'b1;
		t_reg;
		t_hw;
		t_diag;
		t_lost;
		end_sim;
	end

	// Watchdog, far beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		end_sim;
	end
endmodule
